// ==== inc/i2sdma_pkg.sv ====
// Constants and carriers of the audio sample DMA and pin handling block
// Contract
// - memory moves only while direction enabled
// - pointer double-buffered, reloaded every word count
// - pointer-taken event on each pointer copy
// - one common word count, 32-bit words
// - 8/16-bit samples packed four/two per word
// - 24-bit sample right-aligned, sign-extended
// - stereo stores left/right pairs, same layout
// - mono receive keeps selected channel only
// - mono transmit sends sample on both halves
// - pins taken whenever module enabled
// - device sets pin directions itself
// - master drives mck, frame, bit, data out
// - slave drives mck and data out only
// - pointer-taken once per word count after start
// - stop ends transfer, stops mck, raises stopped
`default_nettype none
package i2sdma_pkg;
    // ----------
    // Register offsets
    // ----------
    localparam logic [11:0] OFS_START    = 12'h000;
    localparam logic [11:0] OFS_STOP     = 12'h004;
    localparam logic [11:0] OFS_EV_RXPTR = 12'h104;
    localparam logic [11:0] OFS_EV_STOP  = 12'h108;
    localparam logic [11:0] OFS_EV_TXPTR = 12'h114;
    localparam logic [11:0] OFS_ENABLE   = 12'h500;
    localparam logic [11:0] OFS_MODE     = 12'h504;
    localparam logic [11:0] OFS_RXEN     = 12'h508;
    localparam logic [11:0] OFS_TXEN     = 12'h50c;
    localparam logic [11:0] OFS_MCKEN    = 12'h510;
    localparam logic [11:0] OFS_SWIDTH   = 12'h51c;
    localparam logic [11:0] OFS_CHANNELS = 12'h528;
    localparam logic [11:0] OFS_RXPTR    = 12'h538;
    localparam logic [11:0] OFS_TXPTR    = 12'h540;
    localparam logic [11:0] OFS_WORDCNT  = 12'h550;
    localparam logic [11:0] OFS_STATUS   = 12'h600;
    localparam logic [11:0] OFS_PINSEL   = 12'h560;
    localparam int          NUM_PINS     = 5;
    localparam int          CNT_W        = 14;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    // ----------
    // Field codes
    // ----------
    localparam logic [1:0]  SW_8         = 2'h0;
    localparam logic [1:0]  SW_16        = 2'h1;
    localparam logic [1:0]  SW_24        = 2'h2;
    localparam logic [1:0]  CH_STEREO    = 2'h0;
    localparam logic [1:0]  CH_LEFT      = 2'h1;
    localparam logic [1:0]  CH_RIGHT     = 2'h2;
    // ----------
    // Carriers
    // ----------
    typedef struct packed {
        logic        right;
        logic [23:0] data;
    } i2sdma_smp_t;
    typedef struct packed {
        logic master_clock_out;
        logic frame_clock;
        logic sck;
        logic serial_data_output;
    } i2sdma_pins_t;
    typedef struct packed {
        logic sck;
        logic sck_rise;
        logic frame_clock;
        logic serial_data_input;
    } i2sdma_link_t;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_RD   = 2'b01,
        MS_WR   = 2'b10
    } i2sdma_mst_t;
endpackage
`default_nettype wire

// ==== rtl/i2sdma_core.sv ====
// Sample DMA, sample packing and pin ownership of the audio serial port
//
// Our own choices: the APB register port and the placing of the registers.
`default_nettype none
module i2sdma_core (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     ce,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          mem_req,
    output logic                          mem_we,
    output logic [31:0]                   mem_addr,
    output logic [31:0]                   mem_wdata,
    input  wire logic [31:0]              mem_rdata,
    input  wire logic                     mem_ack,
    output logic                          running,
    output logic                          mck_run,
    output i2sdma_pkg::i2sdma_smp_t       tx_smp,
    output logic                          tx_smp_valid,
    input  wire logic                     tx_smp_ready,
    input  wire i2sdma_pkg::i2sdma_smp_t  rx_smp,
    input  wire logic                     rx_smp_valid,
    output logic                          rx_smp_ready,
    input  wire i2sdma_pkg::i2sdma_pins_t gen_pins,
    output i2sdma_pkg::i2sdma_pins_t      pin_out,
    output i2sdma_pkg::i2sdma_pins_t      pin_oe_n,
    output logic [4:0]                    pin_taken,
    input  wire logic                     sck_pin,
    input  wire logic                     frame_clock_pin,
    input  wire logic                     serial_data_input_pin,
    output i2sdma_pkg::i2sdma_link_t      link
);
    import i2sdma_pkg::*;

    // ----------
    // Helpers
    // ----------
    function automatic logic [1:0] last_lane(input logic [1:0] sw);
        last_lane = (sw == SW_8) ? 2'd3 : (sw == SW_16) ? 2'd1 : 2'd0;
    endfunction

    function automatic logic [23:0] get_smp(input logic [31:0] w, input logic [1:0] ln,
                                            input logic [1:0] sw);
        get_smp = 24'h0;
        unique case (sw)
            SW_8:    get_smp = {16'h0, w[8*ln +: 8]};
            SW_16:   get_smp = {8'h0, w[16*ln[0] +: 16]};
            default: get_smp = w[23:0];
        endcase
    endfunction

    function automatic logic [31:0] put_smp(input logic [31:0] w, input logic [1:0] ln,
                                            input logic [1:0] sw, input logic [23:0] s);
        put_smp = w;
        unique case (sw)
            SW_8:    put_smp[8*ln +: 8] = s[7:0];
            SW_16:   put_smp[16*ln[0] +: 16] = s[15:0];
            default: put_smp = {{8{s[23]}}, s};
        endcase
    endfunction

    // ----------
    // Registers
    // ----------
    logic             enable_ff, slave_ff, receive_enable_ff, transmit_enable_ff, mcken_ff;
    logic [1:0]       sample_width_ff, chan_ff;
    logic [31:0]      rx_buffer_pointer_ff, tx_buffer_pointer_ff;
    logic [CNT_W-1:0] buffer_word_count_ff;
    logic [4:0]       pinsel_ff;
    logic             tx_pointer_taken_event_ff, rx_pointer_taken_event_ff, stopped_ev_ff;
    logic             running_ff;
    logic [31:0]      prdata_ff;
    logic             wr, rd_setup, start_wr, stop_wr;
    logic             tx_reload, rx_reload, start_go;

    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign start_wr = wr & (paddr == OFS_START) & pwdata[0];
    assign stop_wr  = wr & (paddr == OFS_STOP) & pwdata[0];
    assign start_go = start_wr & enable_ff;
    assign pready   = penable;

    always_comb begin
        pslverr = 1'b0;
        unique case (paddr)
            OFS_START, OFS_STOP, OFS_EV_RXPTR, OFS_EV_STOP, OFS_EV_TXPTR, OFS_ENABLE,
            OFS_MODE, OFS_RXEN, OFS_TXEN, OFS_MCKEN, OFS_SWIDTH, OFS_CHANNELS,
            OFS_RXPTR, OFS_TXPTR, OFS_WORDCNT, OFS_STATUS, OFS_PINSEL: pslverr = 1'b0;
            default: pslverr = psel & penable;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_ff            <= 1'b0;
            slave_ff             <= 1'b0;
            receive_enable_ff    <= 1'b0;
            transmit_enable_ff   <= 1'b0;
            mcken_ff             <= 1'b0;
            sample_width_ff      <= SW_8;
            chan_ff              <= CH_STEREO;
            rx_buffer_pointer_ff <= RST_WORD;
            tx_buffer_pointer_ff <= RST_WORD;
            buffer_word_count_ff <= '0;
            pinsel_ff            <= '0;
        end else if (ce && wr) begin
            unique case (paddr)
                OFS_ENABLE:   enable_ff <= pwdata[0];
                OFS_MODE:     slave_ff <= pwdata[0];
                OFS_RXEN:     receive_enable_ff <= pwdata[0];
                OFS_TXEN:     transmit_enable_ff <= pwdata[0];
                OFS_MCKEN:    mcken_ff <= pwdata[0];
                OFS_SWIDTH:   sample_width_ff <= pwdata[1:0];
                OFS_CHANNELS: chan_ff <= pwdata[1:0];
                OFS_RXPTR:    rx_buffer_pointer_ff <= pwdata;
                OFS_TXPTR:    tx_buffer_pointer_ff <= pwdata;
                OFS_WORDCNT:  buffer_word_count_ff <= pwdata[CNT_W-1:0];
                OFS_PINSEL:   pinsel_ff <= pwdata[4:0];
                default:      ;
            endcase
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_pointer_taken_event_ff <= 1'b0;
            rx_pointer_taken_event_ff <= 1'b0;
            stopped_ev_ff             <= 1'b0;
        end else if (ce) begin
            if (tx_reload || (start_go && transmit_enable_ff))
                tx_pointer_taken_event_ff <= 1'b1;
            else if (wr && paddr == OFS_EV_TXPTR && !pwdata[0])
                tx_pointer_taken_event_ff <= 1'b0;
            if (rx_reload || (start_go && receive_enable_ff))
                rx_pointer_taken_event_ff <= 1'b1;
            else if (wr && paddr == OFS_EV_RXPTR && !pwdata[0])
                rx_pointer_taken_event_ff <= 1'b0;
            if (stop_wr)
                stopped_ev_ff <= 1'b1;
            else if (wr && paddr == OFS_EV_STOP && !pwdata[0])
                stopped_ev_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            running_ff <= 1'b0;
        end else if (ce) begin
            if (stop_wr || !enable_ff)
                running_ff <= 1'b0;
            else if (start_go)
                running_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_ff <= RST_WORD;
        end else if (ce && rd_setup) begin
            unique case (paddr)
                OFS_EV_RXPTR: prdata_ff <= {31'h0, rx_pointer_taken_event_ff};
                OFS_EV_STOP:  prdata_ff <= {31'h0, stopped_ev_ff};
                OFS_EV_TXPTR: prdata_ff <= {31'h0, tx_pointer_taken_event_ff};
                OFS_ENABLE:   prdata_ff <= {31'h0, enable_ff};
                OFS_MODE:     prdata_ff <= {31'h0, slave_ff};
                OFS_RXEN:     prdata_ff <= {31'h0, receive_enable_ff};
                OFS_TXEN:     prdata_ff <= {31'h0, transmit_enable_ff};
                OFS_MCKEN:    prdata_ff <= {31'h0, mcken_ff};
                OFS_SWIDTH:   prdata_ff <= {30'h0, sample_width_ff};
                OFS_CHANNELS: prdata_ff <= {30'h0, chan_ff};
                OFS_RXPTR:    prdata_ff <= rx_buffer_pointer_ff;
                OFS_TXPTR:    prdata_ff <= tx_buffer_pointer_ff;
                OFS_WORDCNT:  prdata_ff <= {{(32-CNT_W){1'b0}}, buffer_word_count_ff};
                OFS_STATUS:   prdata_ff <= {31'h0, running_ff};
                OFS_PINSEL:   prdata_ff <= {27'h0, pinsel_ff};
                default:      prdata_ff <= RST_WORD;
            endcase
        end
    end
    assign prdata = prdata_ff;

    // ----------
    // Sample packing
    // ----------
    logic [31:0] tx_word_ff, rx_word_ff;
    logic [1:0]  tx_lane_ff, rx_lane_ff;
    logic        tx_have_ff, tx_rep_ff, rx_full_ff;
    logic        tx_take, rx_take, rx_keep, stereo;
    logic        tx_fetched, rx_stored;

    assign stereo       = (chan_ff == CH_STEREO);
    assign tx_smp_valid = tx_have_ff;
    assign tx_smp.data  = get_smp(tx_word_ff, tx_lane_ff, sample_width_ff);
    assign tx_smp.right = tx_rep_ff;
    assign tx_take      = tx_have_ff & tx_smp_ready;
    assign rx_smp_ready = running_ff & receive_enable_ff & ~rx_full_ff;
    assign rx_take      = rx_smp_valid & rx_smp_ready;
    assign rx_keep      = stereo | (rx_smp.right == (chan_ff == CH_RIGHT));

    // Stereo walks lanes as left/right pairs; mono repeats each lane twice
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_word_ff <= RST_WORD;
            tx_lane_ff <= 2'd0;
            tx_have_ff <= 1'b0;
            tx_rep_ff  <= 1'b0;
        end else if (ce) begin
            if (!running_ff) begin
                tx_have_ff <= 1'b0;
                tx_lane_ff <= 2'd0;
                tx_rep_ff  <= 1'b0;
            end else if (tx_fetched) begin
                tx_word_ff <= mem_rdata;
                tx_have_ff <= 1'b1;
                tx_lane_ff <= 2'd0;
            end else if (tx_take) begin
                tx_rep_ff <= ~tx_rep_ff;
                if (stereo || tx_rep_ff) begin
                    if (tx_lane_ff == last_lane(sample_width_ff))
                        tx_have_ff <= 1'b0;
                    tx_lane_ff <= tx_lane_ff + 2'd1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_word_ff <= RST_WORD;
            rx_lane_ff <= 2'd0;
            rx_full_ff <= 1'b0;
        end else if (ce) begin
            if (!running_ff) begin
                rx_full_ff <= 1'b0;
                rx_lane_ff <= 2'd0;
            end else if (rx_stored) begin
                rx_full_ff <= 1'b0;
            end else if (rx_take && rx_keep) begin
                rx_word_ff <= put_smp(rx_word_ff, rx_lane_ff, sample_width_ff,
                                      rx_smp.data);
                if (rx_lane_ff == last_lane(sample_width_ff)) begin
                    rx_full_ff <= 1'b1;
                    rx_lane_ff <= 2'd0;
                end else begin
                    rx_lane_ff <= rx_lane_ff + 2'd1;
                end
            end
        end
    end

    // ----------
    // Memory master and pointer double buffers
    // ----------
    i2sdma_mst_t      mst_ff;
    logic [31:0]      tx_act_ptr_ff, rx_act_ptr_ff;
    logic [CNT_W-1:0] tx_cnt_ff, rx_cnt_ff;
    logic             tx_last, rx_last;

    assign tx_fetched = (mst_ff == MS_RD) & mem_ack;
    assign rx_stored  = (mst_ff == MS_WR) & mem_ack;
    assign tx_last    = (tx_cnt_ff + 1'b1) >= buffer_word_count_ff;
    assign rx_last    = (rx_cnt_ff + 1'b1) >= buffer_word_count_ff;
    assign tx_reload  = tx_fetched & tx_last;
    assign rx_reload  = rx_stored & rx_last;

    // Writes go first at idle, so received audio waits at most for a fetch already under way
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mst_ff <= MS_IDLE;
        end else if (ce) begin
            unique case (mst_ff)
                MS_IDLE: begin
                    if (running_ff && receive_enable_ff && rx_full_ff)
                        mst_ff <= MS_WR;
                    else if (running_ff && transmit_enable_ff && !tx_have_ff)
                        mst_ff <= MS_RD;
                end
                MS_RD, MS_WR: begin
                    if (mem_ack)
                        mst_ff <= MS_IDLE;
                end
                default: mst_ff <= MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_act_ptr_ff <= RST_WORD;
            rx_act_ptr_ff <= RST_WORD;
            tx_cnt_ff     <= '0;
            rx_cnt_ff     <= '0;
        end else if (ce) begin
            if (start_go) begin
                tx_act_ptr_ff <= tx_buffer_pointer_ff;
                rx_act_ptr_ff <= rx_buffer_pointer_ff;
                tx_cnt_ff     <= '0;
                rx_cnt_ff     <= '0;
            end else begin
                if (tx_reload) begin
                    tx_act_ptr_ff <= tx_buffer_pointer_ff;
                    tx_cnt_ff     <= '0;
                end else if (tx_fetched) begin
                    tx_cnt_ff <= tx_cnt_ff + 1'b1;
                end
                if (rx_reload) begin
                    rx_act_ptr_ff <= rx_buffer_pointer_ff;
                    rx_cnt_ff     <= '0;
                end else if (rx_stored) begin
                    rx_cnt_ff <= rx_cnt_ff + 1'b1;
                end
            end
        end
    end

    assign mem_req   = (mst_ff != MS_IDLE);
    assign mem_we    = (mst_ff == MS_WR);
    assign mem_addr  = mem_we ? rx_act_ptr_ff + {{(30-CNT_W){1'b0}}, rx_cnt_ff, 2'b00}
                              : tx_act_ptr_ff + {{(30-CNT_W){1'b0}}, tx_cnt_ff, 2'b00};
    assign mem_wdata = rx_word_ff;
    assign running   = running_ff;
    assign mck_run   = running_ff & mcken_ff;

    // ----------
    // Pins
    // ----------
    logic [2:0] sck_s1_ff, sck_s2_ff;
    logic       sck_d_ff;

    // Output enables are low while driving; a disabled port releases all
    always_comb begin
        pin_oe_n.master_clock_out                = ~enable_ff;
        pin_oe_n.serial_data_output = ~enable_ff;
        pin_oe_n.frame_clock        = ~(enable_ff & ~slave_ff);
        pin_oe_n.sck                = ~(enable_ff & ~slave_ff);
        pin_out.master_clock_out                 = gen_pins.master_clock_out & mck_run;
        pin_out.frame_clock         = gen_pins.frame_clock & running_ff;
        pin_out.sck                 = gen_pins.sck & running_ff;
        pin_out.serial_data_output  = gen_pins.serial_data_output & running_ff;
    end
    assign pin_taken = enable_ff ? pinsel_ff : 5'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_s1_ff <= 3'h0;
            sck_s2_ff <= 3'h0;
            sck_d_ff  <= 1'b0;
        end else if (ce) begin
            sck_s1_ff <= {sck_pin, frame_clock_pin, serial_data_input_pin};
            sck_s2_ff <= sck_s1_ff;
            sck_d_ff  <= sck_s2_ff[2];
        end
    end
    assign link.sck               = sck_s2_ff[2];
    assign link.sck_rise          = sck_s2_ff[2] & ~sck_d_ff;
    assign link.frame_clock       = sck_s2_ff[1];
    assign link.serial_data_input = sck_s2_ff[0];
endmodule
`default_nettype wire

// ==== tb/i2sdma_chk.sv ====
// Port assertions for the audio sample DMA block
`default_nettype none
module i2sdma_chk (
    input wire logic                     clk,
    input wire logic                     rstn,
    input wire logic                     penable,
    input wire logic                     pready,
    input wire logic                     mem_req,
    input wire logic                     mem_ack,
    input wire logic [31:0]              mem_addr,
    input wire logic                     running,
    input wire logic                     mck_run,
    input wire i2sdma_pkg::i2sdma_smp_t  tx_smp,
    input wire logic                     tx_smp_valid,
    input wire logic                     tx_smp_ready,
    input wire logic                     rx_smp_ready,
    input wire i2sdma_pkg::i2sdma_pins_t pin_out,
    input wire i2sdma_pkg::i2sdma_pins_t pin_oe_n,
    input wire logic [4:0]               pin_taken
);
    import i2sdma_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_apb_ready: assert property (pready == penable) else $error("bad pready");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("mem request dropped");
    a_mem_gap: assert property (mem_req && mem_ack |=> !mem_req) else $error("no mem gap");
    a_mem_run: assert property (mem_req |-> running) else $error("idle access");
    a_rx_idle: assert property (!running |-> !rx_smp_ready) else $error("idle rx");
    a_tx_hold: assert property (tx_smp_valid && !tx_smp_ready |=> $stable(tx_smp))
        else $error("tx sample changed");
    a_mck_stop: assert property (!mck_run |-> !pin_out.master_clock_out) else $error("mck runs");
    a_out_idle: assert property (!running |-> pin_out[2:0] == 3'h0)
        else $error("pins active idle");
    a_mck_own: assert property (pin_oe_n.master_clock_out == !pin_taken[0])
        else $error("mck direction");
    a_sck_free: assert property (!pin_taken[1] |-> pin_oe_n.sck) else $error("sck held");
    c_mem: cover property (mem_req && mem_ack);
    c_tx: cover property (tx_smp_valid && tx_smp_ready && tx_smp.right);
    c_slave: cover property (pin_taken[1] && pin_oe_n.sck);
endmodule
`default_nettype wire

// ==== tb/i2sdma_far.sv ====
// Behavioural codec facing the sample streams and the serial link pins
`default_nettype none
module i2sdma_far (
    input  wire logic                    clk,
    input  wire logic                    on,
    input  wire i2sdma_pkg::i2sdma_smp_t tx_smp,
    input  wire logic                    tx_smp_valid,
    output logic                         tx_smp_ready,
    output i2sdma_pkg::i2sdma_smp_t      rx_smp,
    output logic                         rx_smp_valid,
    input  wire logic                    rx_smp_ready,
    output logic                         sck_pin,
    output logic                         frame_clock_pin,
    output logic                         serial_data_input_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import i2sdma_pkg::*;
    i2sdma_smp_t txq [0:15];
    logic [23:0] rxv [0:7];
    int          tn, rn, rlen;
    logic [3:0]  bc = 4'h0;
    // Ready toggles only while streaming, so each sample after the first of a word meets a stall
    initial tx_smp_ready = 1'b0;
    always @(posedge clk) begin
        tx_smp_ready <= on & ~tx_smp_ready;
        if (tx_smp_valid && tx_smp_ready) begin
            txq[tn] <= tx_smp;
            tn <= tn + 1;
        end
        if (rx_smp_valid && rx_smp_ready) rn <= rn + 1;
    end
    assign rx_smp_valid = rn < rlen;
    // Past the loaded samples the data is inverted so stale values never match
    assign rx_smp = {rn[0], rx_smp_valid ? rxv[rn[2:0]] : ~rxv[rn[2:0]]};
    // Bit clock runs only while streaming, toggles straight through frames and rests low while stopped
    initial begin
        {sck_pin, frame_clock_pin, serial_data_input_pin} = 3'h0;
        forever begin
            #80;
            sck_pin = on & ~sck_pin;
            if (!sck_pin) bc = bc + 4'h1;
            serial_data_input_pin = bc[1] ^ on;
            if (!sck_pin && bc == 4'h0) frame_clock_pin = ~frame_clock_pin;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench of the audio sample DMA block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import i2sdma_pkg::*;
    logic         clk, rstn, ce, psel, penable, pwrite, pready, pslverr, e, on;
    logic         mem_req, mem_we, mem_ack, running, mck_run, tx_smp_valid, tx_smp_ready;
    logic         rx_smp_valid, rx_smp_ready, sck_pin, frame_clock_pin, serial_data_input_pin;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, mem_addr, mem_wdata, mem_rdata, r;
    logic [31:0]  mem [0:31];
    logic [4:0]   pin_taken;
    i2sdma_smp_t  tx_smp, rx_smp;
    i2sdma_pins_t gen_pins, pin_out, pin_oe_n;
    i2sdma_link_t link;
    int           num_errors, compares, nwr, nrd, n;
    i2sdma_core i2sdma_core_inst (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_ack, .running, .mck_run, .tx_smp, .tx_smp_valid, .tx_smp_ready, .rx_smp,
        .rx_smp_valid, .rx_smp_ready, .gen_pins, .pin_out, .pin_oe_n, .pin_taken, .sck_pin,
        .frame_clock_pin, .serial_data_input_pin, .link);
    i2sdma_far i2sdma_far_inst (.clk, .on, .tx_smp, .tx_smp_valid, .tx_smp_ready, .rx_smp,
        .rx_smp_valid, .rx_smp_ready, .sck_pin, .frame_clock_pin, .serial_data_input_pin);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Memory answers one cycle after it sees a request
    always @(posedge clk) begin
        gen_pins <= i2sdma_pins_t'(gen_pins + 4'h1);
        mem_ack <= mem_req & ~mem_ack;
        mem_rdata <= mem[mem_addr[6:2]];
        if (mem_req & mem_ack & mem_we) mem[mem_addr[6:2]] <= mem_wdata;
        if (mem_req & mem_ack & mem_we) nwr <= nwr + 1;
        if (mem_req & mem_ack & !mem_we) nrd <= nrd + 1;
    end
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, x, r);
    endtask
    task automatic stop;
        on <= 1'b0;
        wr(OFS_STOP, 32'h1);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, on, mem_ack, gen_pins} = '0;
        ce = 1'b1;
        mem[8] = 32'h2222_1111;
        mem[9] = 32'h4444_3333;
        mem[16] = 32'h6666_5555;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("oe", 32'hf, 32'(pin_oe_n));
        rd(OFS_ENABLE, 32'h0, "enable");
        apb(1'b0, 12'h7fc, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        chk("rzero", 32'h0, r);
        // Bring-up order: settings, pins, pointer, count, enable, start
        wr(OFS_TXEN, 32'h1);
        wr(OFS_MCKEN, 32'h1);
        wr(OFS_SWIDTH, 32'(SW_16));
        wr(OFS_PINSEL, 32'h1f);
        wr(OFS_TXPTR, 32'h20);
        wr(OFS_WORDCNT, 32'h2);
        wr(OFS_ENABLE, 32'h1);
        @(negedge clk);
        chk("oe", 32'h0, 32'(pin_oe_n));
        chk("taken", 32'h1f, 32'(pin_taken));
        wr(OFS_START, 32'h1);
        rd(OFS_EV_TXPTR, 32'h1, "txev");
        wr(OFS_TXPTR, 32'h40);
        wr(OFS_EV_TXPTR, 32'h0);
        on <= 1'b1;
        wait (i2sdma_far_inst.tn >= 5);
        for (int i = 0; i < 5; i++) chk("tx16", {7'h0, i[0], 8'h0, 16'(16'h1111 * (i + 1))},
            32'(i2sdma_far_inst.txq[i]));
        rd(OFS_EV_TXPTR, 32'h1, "txev");
        chk("mck", 32'h1, 32'(mck_run));
        chk("nowr", 32'h0, 32'(nwr));
        stop;
        rd(OFS_EV_STOP, 32'h1, "stopev");
        chk("run", 32'h0, 32'(running));
        i2sdma_far_inst.tn = 0;
        mem[8] = 32'hff80_0001;
        wr(OFS_SWIDTH, 32'(SW_24));
        wr(OFS_CHANNELS, 32'(CH_LEFT));
        wr(OFS_TXPTR, 32'h20);
        wr(OFS_START, 32'h1);
        on <= 1'b1;
        wait (i2sdma_far_inst.tn >= 2);
        for (int i = 0; i < 2; i++) chk("mono", {7'h0, i[0], 24'h80_0001},
            32'(i2sdma_far_inst.txq[i]));
        stop;
        wr(OFS_TXEN, 32'h0);
        wr(OFS_RXEN, 32'h1);
        wr(OFS_SWIDTH, 32'(SW_8));
        wr(OFS_CHANNELS, 32'(CH_STEREO));
        wr(OFS_RXPTR, 32'h60);
        wr(OFS_WORDCNT, 32'h1);
        for (int i = 0; i < 4; i++) i2sdma_far_inst.rxv[i] = {3{8'(8'h11 * (i + 1))}};
        i2sdma_far_inst.rlen = 4;
        n = nrd;
        wr(OFS_START, 32'h1);
        wait (nwr >= 1);
        @(negedge clk);
        chk("rx8", 32'h4433_2211, mem[24]);
        rd(OFS_EV_RXPTR, 32'h1, "rxev");
        chk("nord", 32'(n), 32'(nrd));
        stop;
        wr(OFS_SWIDTH, 32'(SW_24));
        wr(OFS_CHANNELS, 32'(CH_LEFT));
        wr(OFS_WORDCNT, 32'h2);
        i2sdma_far_inst.rxv[0] = 24'h80_0001;
        i2sdma_far_inst.rxv[1] = 24'h12_3456;
        i2sdma_far_inst.rxv[2] = 24'h7f_ffff;
        i2sdma_far_inst.rn = 0;
        wr(OFS_START, 32'h1);
        wait (nwr >= 3);
        @(negedge clk);
        chk("rx24", 32'hff80_0001, mem[24]);
        chk("rx24", 32'h007f_ffff, mem[25]);
        stop;
        wr(OFS_MODE, 32'h1);
        @(negedge clk);
        chk("oe", 32'h6, 32'(pin_oe_n));
        wr(OFS_ENABLE, 32'h0);
        @(negedge clk);
        chk("oe", 32'hf, 32'(pin_oe_n));
        chk("taken", 32'h0, 32'(pin_taken));
        print_verdict;
    end
endmodule
bind i2sdma_core i2sdma_chk i2sdma_chk_inst (.clk, .rstn, .penable, .pready, .mem_req,
    .mem_ack, .mem_addr, .running, .mck_run, .tx_smp, .tx_smp_valid, .tx_smp_ready,
    .rx_smp_ready, .pin_out, .pin_oe_n, .pin_taken);
`default_nettype wire
